// ### verilog/sram_port.v
// pipelined synchronous memory port with double-cycle deselect
// assumes the controller keeps the bus rules; oe_n and sleep_request come
// straight from pins and are used without registers
//
// Functional notes
// RULE1: all synchronous inputs registered on rising edge
// RULE2: load address only when a strobe asserted
// RULE3: 256K words; low address bits seed counter
// RULE4: advance low steps the burst counter
// RULE5: interleaved or linear burst order selectable
// RULE6: registered writes complete as self-timed cycle
// RULE7: byte lane selects write one to four lanes
// RULE8: global write low writes all lanes
// RULE9: byte write enable low qualifies lane selects
// RULE10: outputs stay on one cycle after deselect
// RULE11: processor strobe ignored when chip select high
// RULE12: chip select sampled only on address load
// RULE13: selected only when all chip selects active
// RULE14: first access three cycles, bursts one each
// RULE15: output enable and sleep act asynchronously
// RULE16: depth selects sampled only on address load
// RULE17: both strobes: processor strobe takes precedence
// RULE18: oe masked first read clock after deselect
// RULE19: read data from previous edge's address
// RULE20: lanes a..d map to bytes 0..3
// RULE21: burst counter wraps within four words
`timescale 1ns/1ps
`include "sram_port_defines.vh"
module sram_port #(
	parameter ADDR_WIDTH = `ADDR_WIDTH,
	parameter DATA_WIDTH = `DATA_WIDTH
) (
	// clock and reset
	input wire sys_clk,
	input wire reset,
	// address and strobes
	input wire [ADDR_WIDTH-1:0] address,
	input wire processor_address_strobe_n,
	input wire controller_address_strobe_n,
	input wire burst_advance_n,
	input wire linear_burst_mode,
	// chip selects
	input wire pipelined_chip_select_n,
	input wire depth_select_high,
	input wire depth_select_low_n,
	// write controls
	input wire global_write_n,
	input wire byte_write_enable_n,
	input wire byte_lane_select_a_n,
	input wire byte_lane_select_b_n,
	input wire byte_lane_select_c_n,
	input wire byte_lane_select_d_n,
	// asynchronous controls
	input wire output_enable_n,
	input wire sleep_request,
	// data pins, split into three signals
	input wire [DATA_WIDTH-1:0] data_in,
	output reg [DATA_WIDTH-1:0] data_out,
	output wire data_out_enable
);
	localparam DEPTH = 1 << ADDR_WIDTH;
	localparam LANE_WIDTH = `LANE_WIDTH;

	// registered address and burst state
	reg [ADDR_WIDTH-1:0] addr_reg;
	reg [`BURST_BITS-1:0] start_reg;
	reg [`BURST_BITS-1:0] count_reg;
	reg linear_reg;
	reg selected_reg;
	reg cycle_valid_reg;

	// registered write controls and data
	reg [DATA_WIDTH-1:0] wdata_reg;
	reg [`LANE_COUNT-1:0] lane_n_reg;
	reg gw_n_reg;
	reg bwe_n_reg;

	// read pipeline
	reg read_stage_reg;
	reg enable_reg;
	reg enable_delay_reg;
	reg mask_reg;
	reg [`BURST_BITS-1:0] burst_low;

	// strobe decode
	wire [`LANE_COUNT-1:0] lane_n_in;
	wire load_p;
	wire load_c;
	wire load;
	wire chip_on;
	wire step;
	// burst address
	wire [`BURST_BITS-1:0] count_next;
	wire [ADDR_WIDTH-1:0] cur_addr;
	// write and read slots
	wire [`LANE_COUNT-1:0] lane_we;
	wire write_slot;
	wire read_slot;
	wire [DATA_WIDTH-1:0] rd_word;

	assign lane_n_in = {byte_lane_select_d_n, byte_lane_select_c_n,
		byte_lane_select_b_n, byte_lane_select_a_n}; // [RULE20]

	// processor strobe only counts with chip select low; it also wins a tie
	assign load_p = !processor_address_strobe_n && !pipelined_chip_select_n; // [RULE11] [RULE17]
	assign load_c = !controller_address_strobe_n && !load_p;
	assign load = load_p || load_c; // [RULE2]

	// selects only looked at on load edges
	assign chip_on = !pipelined_chip_select_n && depth_select_high &&
		!depth_select_low_n; // [RULE12] [RULE13] [RULE16]

	// advance only matters inside a selected burst
	assign step = !load && !burst_advance_n && selected_reg; // [RULE4]

	assign count_next = count_reg + 2'h1; // [RULE4] [RULE21]

	// interleave is xor of start with step, linear is add; both stay in the block
	always @* begin
		if (linear_reg) begin
			burst_low = start_reg + count_reg; // [RULE5] [RULE21]
		end else begin
			burst_low = start_reg ^ count_reg; // [RULE5]
		end
	end

	assign cur_addr = {addr_reg[ADDR_WIDTH-1:`BURST_BITS], burst_low}; // [RULE3]

	// sleep blocks writes so the array keeps its contents
	assign write_slot = selected_reg && cycle_valid_reg && !sleep_request; // [RULE6]
	// a live cycle with no lane written is a read
	assign read_slot = selected_reg && cycle_valid_reg && (lane_we == {`LANE_COUNT{1'b0}});

	// address and burst state; selects are only looked at on load edges
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			addr_reg <= {ADDR_WIDTH{1'b0}};
			start_reg <= `BURST_RESET;
			count_reg <= `BURST_RESET;
			linear_reg <= 1'b0;
			selected_reg <= `ENABLE_RESET;
			cycle_valid_reg <= 1'b0;
		end else begin
			cycle_valid_reg <= load || step;
			if (load) begin
				addr_reg <= address; // [RULE2] [RULE3]
				start_reg <= address[`BURST_BITS-1:0]; // [RULE3]
				count_reg <= `BURST_RESET;
				linear_reg <= linear_burst_mode;
				selected_reg <= chip_on; // [RULE12] [RULE13] [RULE16]
			end else if (step) begin
				count_reg <= count_next; // [RULE4]
			end
		end
	end

	// write controls and data are captured on every edge
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wdata_reg <= {DATA_WIDTH{1'b0}};
			lane_n_reg <= {`LANE_COUNT{1'b1}};
			gw_n_reg <= 1'b1;
			bwe_n_reg <= 1'b1;
		end else begin
			wdata_reg <= data_in; // [RULE1] [RULE6]
			lane_n_reg <= lane_n_in; // [RULE1]
			gw_n_reg <= global_write_n; // [RULE1]
			bwe_n_reg <= byte_write_enable_n; // [RULE1]
		end
	end

	// one byte-wide array per lane, so every lane has a single writer
	genvar lane;
	generate
		for (lane = 0; lane < `LANE_COUNT; lane = lane + 1) begin : g_lane
			reg [LANE_WIDTH-1:0] lane_mem [0:DEPTH-1];

			// global write overrides the lane controls
			assign lane_we[lane] = !gw_n_reg ||
				(!bwe_n_reg && !lane_n_reg[lane]); // [RULE7] [RULE8] [RULE9]

			// self-timed write one edge after capture
			always @(posedge sys_clk) begin
				if (write_slot && lane_we[lane]) begin
					lane_mem[cur_addr] <= wdata_reg[lane*LANE_WIDTH +: LANE_WIDTH]; // [RULE6] [RULE7]
				end
			end

			assign rd_word[lane*LANE_WIDTH +: LANE_WIDTH] = lane_mem[cur_addr]; // [RULE20]
		end
	endgenerate

	// read pipeline: capture edge, then output register loaded straight from the array
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			data_out <= {DATA_WIDTH{1'b0}};
			read_stage_reg <= 1'b0;
		end else begin
			read_stage_reg <= read_slot;
			// stage after a read looks again, so the word stands a full cycle
			if (read_stage_reg || (selected_reg && cycle_valid_reg)) begin
				data_out <= rd_word; // [RULE14] [RULE19]
			end
		end
	end

	// output enable pipeline
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			enable_reg <= `ENABLE_RESET;
			enable_delay_reg <= `ENABLE_RESET;
			mask_reg <= 1'b0;
		end else begin
			enable_reg <= selected_reg;
			// extra enable stage holds drivers one cycle past a deselect
			enable_delay_reg <= enable_reg; // [RULE10]
			// first read clock out of deselect masks output enable
			mask_reg <= selected_reg && !enable_reg; // [RULE18]
		end
	end

	// drivers gated combinationally by the async pins; sleep wins over everything
	assign data_out_enable = (enable_reg || enable_delay_reg) && !mask_reg &&
		!output_enable_n && !sleep_request; // [RULE15] [RULE18] [RULE10]
endmodule

// ### verilog/sram_port_defines.vh
// constants for the pipelined double-cycle-deselect sync memory port
// assumes a single clock domain; included by bare name
`ifndef SRAM_PORT_DEFINES_VH
`define SRAM_PORT_DEFINES_VH
`define ADDR_WIDTH 18
`define DATA_WIDTH 32
`define LANE_COUNT 4
`define LANE_WIDTH 8
`define BURST_BITS 2
`define BURST_RESET 2'h0
`define ENABLE_RESET 1'h0
`endif

// ### dv/sram_port_asserts.sv
// pin-level checks for sram_port
// bound to every sram_port; one clock, reset high
`timescale 1ns/1ps
module sram_port_asserts(input wire sys_clk,input wire reset,input wire processor_address_strobe_n,
input wire controller_address_strobe_n,input wire burst_advance_n,input wire pipelined_chip_select_n,
input wire depth_select_high,input wire depth_select_low_n,input wire output_enable_n,
input wire sleep_request,input wire [31:0] data_out,input wire data_out_enable);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
wire ps=processor_address_strobe_n,cs=controller_address_strobe_n,en=data_out_enable;
// three quiet edges flush the pipeline before we judge
sequence idle3; (ps&&cs&&burst_advance_n)[*3]; endsequence
sequence dsl3(c); (ps&&!cs&&c)[*3]; endsequence
chk_oe_off: assert property (output_enable_n|->!en) else $error("drive with oe high");
chk_sleep_off: assert property (sleep_request|->!en) else $error("drive in sleep");
chk_dcd_off: assert property (dsl3(pipelined_chip_select_n)|=>!en) else $error("dcd");
chk_dhi_off: assert property (dsl3(!depth_select_high)|=>!en) else $error("depth high");
chk_dlo_off: assert property (dsl3(depth_select_low_n)|=>!en) else $error("depth low");
chk_idle_hold: assert property (idle3|=>$stable(data_out)) else $error("data moved");
chk_proc_ign: assert property ((!ps&&cs&&pipelined_chip_select_n&&burst_advance_n)[*3]
	|=>$stable(data_out)) else $error("strobe taken");
chk_cs_ignore: assert property ((ps&&cs&&!burst_advance_n&&pipelined_chip_select_n&&en)[*2]
	|=>(output_enable_n||sleep_request||en)) else $error("burst deselected");
endmodule
bind sram_port sram_port_asserts u_chk(.*);

// ### dv/bus_master.sv
// controller model for the synchronous pins
// pins move only at falling edges of sys_clk
`timescale 1ns/1ps
module bus_master(input wire sys_clk);
reg [17:0] a=18'h0;
reg ps_n=1,cs_n=1,adv_n=1,lin=0,ce_n=0,dh=1,dl_n=0,glw_n=1,bwe_n=1,oe_n=0,slp=0;
reg [3:0] lane_n=4'hf;
reg [31:0] d=32'h0;
// one load edge through the controller strobe
task access(input [17:0] ad,input wr,input gl,input [3:0] ln,input [31:0] wd);
	begin
		a=ad; cs_n=0; d=wd; lane_n=ln;
		glw_n=~(wr&gl);
		bwe_n=~(wr&~gl);
		@(negedge sys_clk);
		cs_n=1; glw_n=1; bwe_n=1; lane_n=4'hf;
		d=~wd; // released bus shows no stale value
		@(negedge sys_clk);
	end
endtask
endmodule

// ### dv/sram_port_tb.sv
// self-checking bench for sram_port
// bus_master drives all inputs except sys_clk and reset at falling edges
`timescale 1ns/1ps
module sram_port_tb;
reg sys_clk=0,reset=1;
integer n_fail=0,n_tests=0,cyc=0,i,k;
wire [31:0] q;
wire en;
bus_master M(.sys_clk(sys_clk));
sram_port DUT(.sys_clk(sys_clk),.reset(reset),.address(M.a),.processor_address_strobe_n(M.ps_n),
.controller_address_strobe_n(M.cs_n),.burst_advance_n(M.adv_n),.linear_burst_mode(M.lin),
.pipelined_chip_select_n(M.ce_n),.depth_select_high(M.dh),.depth_select_low_n(M.dl_n),
.global_write_n(M.glw_n),.byte_write_enable_n(M.bwe_n),.byte_lane_select_a_n(M.lane_n[0]),
.byte_lane_select_b_n(M.lane_n[1]),.byte_lane_select_c_n(M.lane_n[2]),
.byte_lane_select_d_n(M.lane_n[3]),.output_enable_n(M.oe_n),.sleep_request(M.slp),
.data_in(M.d),.data_out(q),.data_out_enable(en));
initial forever #4 sys_clk=~sys_clk;
task cmp(input [31:0] e,input [31:0] g);
	begin
		n_tests=n_tests+1;
		if (g!==e) begin
			n_fail=n_fail+1;
			$display("wrong value data_out exp %h got %h",e,g);
		end
	end
endtask
task cmp_en(input e,input g);
	begin
		n_tests=n_tests+1;
		if (g!==e) begin
			n_fail=n_fail+1;
			$display("wrong value data_out_enable exp %b got %b",e,g);
		end
	end
endtask
// n words from ad; chip select held off while bursting
task rd(input [17:0] ad,input l,input integer n);
	begin
		M.lin=l;
		M.access(ad,0,0,4'h0,32'hffff_ffff);
		@(negedge sys_clk);
		M.adv_n=(n<2);
		M.ce_n=(n>1);
		for (i=0;i<n;i=i+1) begin
			@(negedge sys_clk);
			cmp(n<2?32'h1234_56ab:32'ha5a5_0000|((l?ad+i:ad^i)&3),q);
		end
		M.adv_n=1;
		M.ce_n=0;
	end
endtask
task results;
	begin
		$display("tests %0d fails %0d",n_tests,n_fail);
		if (n_fail==0&&n_tests>0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end
endtask
always @(posedge sys_clk) begin
	cyc=cyc+1;
	if (cyc==3000) begin
		n_fail=n_fail+1;
		results;
	end
end
initial begin
	repeat (12) @(negedge sys_clk);
	reset=0;
	M.access(18'h10,1,1,4'hf,32'h1234_5678);
	M.access(18'h10,1,0,4'he,32'h0000_00ab);
	rd(18'h10,0,1);
	$display("test byte write done");
	for (k=0;k<4;k=k+1) M.access(18'h20+k,1,1,4'h0,32'ha5a5_0000|k);
	rd(18'h21,0,4);
	rd(18'h21,1,4);
	$display("test burst done");
	for (k=0;k<4;k=k+1) begin
		@(negedge sys_clk);
		M.cs_n=(k==3);
		M.ps_n=(k!=3);
		M.ce_n=(k==0||k==3);
		M.dh=(k!=1);
		M.dl_n=(k==2);
		repeat (2) @(negedge sys_clk);
		if (k<3) cmp_en(1'b1,en);
		repeat (2) @(negedge sys_clk);
		M.cs_n=1; M.ps_n=1; M.ce_n=0; M.dh=1; M.dl_n=0;
		@(negedge sys_clk);
		if (k<3) cmp_en(1'b0,en);
		rd(18'h10,0,1);
	end
	M.oe_n=1;
	repeat (2) @(negedge sys_clk);
	cmp_en(1'b0,en);
	M.oe_n=0;
	M.slp=1;
	repeat (2) @(negedge sys_clk);
	cmp_en(1'b0,en);
	M.slp=0;
	$display("test deselect done");
	results;
end
endmodule
